// ==== fvirq_pkg.sv ====
package fvirq_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int unsigned NUM_SRC = 19;
   localparam int unsigned NUM_FLAG = 42;
   localparam int unsigned NUM_LEVEL = 4;

   // ------------------------------------------------------------
   // Register byte offsets
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_ENABLE = 8'h00;
   localparam logic [7:0] OFS_PRIO_LOW = 8'h04;
   localparam logic [7:0] OFS_PRIO_HIGH = 8'h08;
   localparam logic [7:0] OFS_FLAGS_LO = 8'h0c;
   localparam logic [7:0] OFS_FLAGS_HI = 8'h10;
   localparam logic [7:0] OFS_CONFIG = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_PENDING = 8'h1c;

   // Field positions
   localparam int unsigned GLOBAL_EN_BIT = 31;
   localparam int unsigned TX_ROUTE_BIT = 0;

   // Reset values
   localparam logic [18:0] SRC_RESET = 19'h00000;
   localparam logic [41:0] FLAG_RESET = 42'h0;
   localparam logic [3:0] ACTIVE_RESET = 4'h0;

   // Sources that can request; the clear bits 13, 15 and 17 never request
   localparam logic [18:0] SRC_VALID_MASK = 19'h55fff;

   // Vector generation
   localparam logic [15:0] VECTOR_BASE = 16'h0003;
   localparam int unsigned VECTOR_SHIFT = 3;

   // ------------------------------------------------------------
   // Source numbers
   // ------------------------------------------------------------
   localparam int unsigned SRC_EXT0 = 0;
   localparam int unsigned SRC_TMR0 = 1;
   localparam int unsigned SRC_EXT1 = 2;
   localparam int unsigned SRC_TMR1 = 3;
   localparam int unsigned SRC_SER0 = 4;
   localparam int unsigned SRC_TMR2 = 5;
   localparam int unsigned SRC_EXT2 = 6;
   localparam int unsigned SRC_SPI = 7;
   localparam int unsigned SRC_CONV = 8;
   localparam int unsigned SRC_PCA = 9;
   localparam int unsigned SRC_SYSFLAG = 10;
   localparam int unsigned SRC_KEYPAD = 11;
   localparam int unsigned SRC_TWOWIRE = 12;
   localparam int unsigned SRC_SER1 = 14;
   localparam int unsigned SRC_TMR3 = 16;
   localparam int unsigned SRC_XFER = 18;

   // ------------------------------------------------------------
   // Flag bit positions in the flag store
   // ------------------------------------------------------------
   localparam int unsigned F_EXT0 = 0;
   localparam int unsigned F_TMR0 = 1;
   localparam int unsigned F_EXT1 = 2;
   localparam int unsigned F_TMR1 = 3;
   localparam int unsigned F_SER0_RX = 4;
   localparam int unsigned F_SER0_TX = 5;
   localparam int unsigned F_TMR2 = 6;
   localparam int unsigned F_EXT2 = 9;
   localparam int unsigned F_SPI = 10;
   localparam int unsigned F_CONV = 11;
   localparam int unsigned F_PCA = 14;
   localparam int unsigned F_SYS = 23;
   localparam int unsigned F_KEYPAD = 31;
   localparam int unsigned F_TWOWIRE = 32;
   localparam int unsigned F_SER1 = 33;
   localparam int unsigned F_TMR3 = 35;
   localparam int unsigned F_XFER = 38;
   localparam int unsigned F_SER0_TX_ALT = 41;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   function automatic logic [15:0] fvirq_vector(input logic [4:0] src);
      fvirq_vector = VECTOR_BASE + {8'h00, src, 3'b000};
   endfunction

   // Higher code is the higher level: 11 over 10 over 01 over 00
   function automatic logic fvirq_outranks(input logic [1:0] cand, input logic [3:0] active);
      logic hit;
      hit = 1'b0;
      for (int unsigned i = 0; i < NUM_LEVEL; i++)
      begin
         if (active[i] && (i >= 32'(cand)))
         begin
            hit = 1'b1;
         end
      end
      fvirq_outranks = !hit;
   endfunction

endpackage

// ==== fvirq_arb_if.sv ====
`timescale 1ns/1ps
interface fvirq_arb_if;
   logic [18:0] req;
   logic [18:0][1:0] level;
   logic win_valid;
   logic [4:0] win_src;
   logic [1:0] win_level;

   modport ctl (output req, output level, input win_valid, input win_src, input win_level);
   modport arb (input req, input level, output win_valid, output win_src, output win_level);
endinterface

// ==== fvirq_arbiter.sv ====
`timescale 1ns/1ps
module fvirq_arbiter
(
   // Request and winner
   fvirq_arb_if.arb arb
);
   import fvirq_pkg::*;

   typedef struct packed
   {
      logic valid;
      logic [4:0] src;
      logic [1:0] level;
   } fvirq_win_type;

   fvirq_win_type w;

   // ------------------------------------------------------------
   // Level first, then lowest source number
   // ------------------------------------------------------------
   always_comb
   begin
      w = '0;
      for (int unsigned n = 0; n < NUM_SRC; n++)
      begin
         // Strict compare keeps the earlier source on a tie
         if (arb.req[n] && (!w.valid || (arb.level[n] > w.level)))
         begin
            w.valid = 1'b1;
            w.src = 5'(n);
            w.level = arb.level[n];
         end
      end
   end

   assign arb.win_valid = w.valid;
   assign arb.win_src = w.src;
   assign arb.win_level = w.level;
endmodule

// ==== fvirq_top.sv ====
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - Sixteen live sources each have an enable bit and two priority bits within one four-level scheme.
// - A source requests only while one of its flags is set and its own enable bit is set.
// - Nothing sampled while the global enable is clear is serviced, whatever the source enables say.
// - Software writes to the flags act exactly like hardware sets and clears.
// - Each source's level is built from one bit of the high bank and one of the low bank.
// - Equal-level ties go to the lowest source number, and reserved numbers 13, 15 and 17 never request.
// - The call for source n goes to address 0x0003 plus eight times n.
// - The system-flag source ORs watchdog, two brown-out, clock, start, stop, two breakpoint and optional transmit flags.
// - The transfer-engine source ORs its complete flag and its two timer overflow flags.
// - Multi-flag sources OR their flags: serial ports, timers 2 and 3, converter and counter array.
// - Priority code 11 is the highest level, then 10, then 01, and 00 is the lowest.
// - A running routine is never pre-empted by a lower level, and the higher level wins on arrival together.
// - Requests are sampled each clock and the samples evaluated the next clock, calling unless blocked.
// - Vectoring clears timer 0 and 1 overflow and edge-mode external flags; other flags stay set.
module fvirq_top
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Peripheral flag set pulses
   input wire logic [fvirq_pkg::NUM_FLAG-1:0] flag_set,
   input wire logic [2:0] ext_edge_mode,
   // CPU sequencer
   input wire logic cpu_call_slot,
   input wire logic cpu_reti,
   output logic irq_call,
   output logic [15:0] irq_vector,
   output logic [4:0] irq_source,
   output logic [1:0] irq_level
);
   import fvirq_pkg::*;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic global_irq_enable;
      logic [18:0] src_enable;
      logic [18:0] prio_low;
      logic [18:0] prio_high;
      logic [41:0] flags;
      logic tx_route;
      logic [18:0] req_sample;
      logic [3:0] active;
      logic call;
      logic [15:0] vector;
      logic [4:0] call_src;
      logic [1:0] call_level;
      logic [31:0] rdata;
      logic slverr;
   } fvirq_state_type;

   fvirq_state_type s_q;
   fvirq_state_type s_d;

   fvirq_arb_if arb_bus ();

   fvirq_arbiter u_arb
   (
      .arb(arb_bus)
   );

   logic setup_phase;
   logic wr_access;
   logic ctl_write;
   logic [18:0] src_req;
   logic [18:0][1:0] src_level;
   logic [41:0] hw_clear;
   logic call_now;
   logic [3:0] released;

   // ------------------------------------------------------------
   // Flag grouping per source
   // ------------------------------------------------------------
   function automatic logic [18:0] fvirq_gather(input logic [41:0] f, input logic tx_route);
      logic [18:0] r;
      r = '0;
      r[SRC_EXT0] = f[F_EXT0];
      r[SRC_TMR0] = f[F_TMR0];
      r[SRC_EXT1] = f[F_EXT1];
      r[SRC_TMR1] = f[F_TMR1];
      r[SRC_SER0] = f[F_SER0_RX] | f[F_SER0_TX];
      r[SRC_TMR2] = |f[F_TMR2 +: 3];
      r[SRC_EXT2] = f[F_EXT2];
      r[SRC_SPI] = f[F_SPI];
      r[SRC_CONV] = |f[F_CONV +: 3];
      r[SRC_PCA] = |f[F_PCA +: 9];
      r[SRC_SYSFLAG] = (|f[F_SYS +: 8]) | (tx_route & f[F_SER0_TX_ALT]);
      r[SRC_KEYPAD] = f[F_KEYPAD];
      r[SRC_TWOWIRE] = f[F_TWOWIRE];
      r[SRC_SER1] = |f[F_SER1 +: 2];
      r[SRC_TMR3] = |f[F_TMR3 +: 3];
      r[SRC_XFER] = |f[F_XFER +: 3];
      fvirq_gather = r & SRC_VALID_MASK;
   endfunction

   // ------------------------------------------------------------
   // Request path
   // ------------------------------------------------------------
   always_comb
   begin
      src_req = fvirq_gather(s_q.flags, s_q.tx_route) & s_q.src_enable;
      if (!s_q.global_irq_enable)
      begin
         src_req = '0;
      end
      for (int unsigned n = 0; n < NUM_SRC; n++)
      begin
         src_level[n] = {s_q.prio_high[n], s_q.prio_low[n]};
      end
   end

   assign arb_bus.req = s_q.req_sample;
   assign arb_bus.level = src_level;

   // ------------------------------------------------------------
   // APB decode helpers
   // ------------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign wr_access = psel && penable && pwrite;
   // Writes to enable, priority or config block the call this cycle
   assign ctl_write = wr_access && ((paddr == OFS_ENABLE) || (paddr == OFS_PRIO_LOW)
                      || (paddr == OFS_PRIO_HIGH) || (paddr == OFS_CONFIG));

   // ------------------------------------------------------------
   // Call decision
   // ------------------------------------------------------------
   assign call_now = arb_bus.win_valid && cpu_call_slot && !cpu_reti && !ctl_write
                     && fvirq_outranks(arb_bus.win_level, s_q.active);

   // Return releases the highest level in progress
   always_comb
   begin
      released = '0;
      for (int unsigned i = 0; i < NUM_LEVEL; i++)
      begin
         if (s_q.active[i])
         begin
            released = '0;
            released[i] = 1'b1;
         end
      end
   end

   // Only timer 0/1 and edge-mode external flags are cleared on entry
   always_comb
   begin
      hw_clear = '0;
      if (call_now)
      begin
         if (arb_bus.win_src == 5'(SRC_TMR0))
         begin
            hw_clear[F_TMR0] = 1'b1;
         end
         else if (arb_bus.win_src == 5'(SRC_TMR1))
         begin
            hw_clear[F_TMR1] = 1'b1;
         end
         else if (arb_bus.win_src == 5'(SRC_EXT0))
         begin
            hw_clear[F_EXT0] = ext_edge_mode[0];
         end
         else if (arb_bus.win_src == 5'(SRC_EXT1))
         begin
            hw_clear[F_EXT1] = ext_edge_mode[1];
         end
         else if (arb_bus.win_src == 5'(SRC_EXT2))
         begin
            hw_clear[F_EXT2] = ext_edge_mode[2];
         end
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      s_d.req_sample = src_req;
      s_d.call = call_now;

      // Register writes land at the access-phase edge
      if (wr_access)
      begin
         if (paddr == OFS_ENABLE)
         begin
            s_d.global_irq_enable = pwdata[GLOBAL_EN_BIT];
            s_d.src_enable = pwdata[18:0] & SRC_VALID_MASK;
         end
         else if (paddr == OFS_PRIO_LOW)
         begin
            s_d.prio_low = pwdata[18:0] & SRC_VALID_MASK;
         end
         else if (paddr == OFS_PRIO_HIGH)
         begin
            s_d.prio_high = pwdata[18:0] & SRC_VALID_MASK;
         end
         else if (paddr == OFS_FLAGS_LO)
         begin
            s_d.flags[31:0] = pwdata;
         end
         else if (paddr == OFS_FLAGS_HI)
         begin
            s_d.flags[41:32] = pwdata[9:0];
         end
         else if (paddr == OFS_CONFIG)
         begin
            s_d.tx_route = pwdata[TX_ROUTE_BIT];
         end
      end

      // Hardware clear, then hardware set; a set in the same cycle wins
      s_d.flags = (s_d.flags & ~hw_clear) | flag_set;

      // Level bookkeeping
      if (cpu_reti)
      begin
         s_d.active = s_q.active & ~released;
      end
      if (call_now)
      begin
         s_d.active[arb_bus.win_level] = 1'b1;
         s_d.vector = fvirq_vector(arb_bus.win_src);
         s_d.call_src = arb_bus.win_src;
         s_d.call_level = arb_bus.win_level;
      end

      // Read data is captured in the setup phase
      if (setup_phase)
      begin
         s_d.slverr = 1'b0;
         if (paddr == OFS_ENABLE)
         begin
            s_d.rdata = {s_q.global_irq_enable, 12'h000, s_q.src_enable};
         end
         else if (paddr == OFS_PRIO_LOW)
         begin
            s_d.rdata = {13'h0000, s_q.prio_low};
         end
         else if (paddr == OFS_PRIO_HIGH)
         begin
            s_d.rdata = {13'h0000, s_q.prio_high};
         end
         else if (paddr == OFS_FLAGS_LO)
         begin
            s_d.rdata = s_q.flags[31:0];
         end
         else if (paddr == OFS_FLAGS_HI)
         begin
            s_d.rdata = {22'h000000, s_q.flags[41:32]};
         end
         else if (paddr == OFS_CONFIG)
         begin
            s_d.rdata = {31'h00000000, s_q.tx_route};
         end
         else if (paddr == OFS_STATUS)
         begin
            s_d.rdata = {25'h0000000, s_q.call_level, s_q.active, s_q.call};
         end
         else if (paddr == OFS_PENDING)
         begin
            s_d.rdata = {13'h0000, s_q.req_sample};
         end
         else
         begin
            s_d.rdata = 32'h00000000;
            s_d.slverr = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         s_q <= '0;
         s_q.src_enable <= SRC_RESET;
         s_q.prio_low <= SRC_RESET;
         s_q.prio_high <= SRC_RESET;
         s_q.flags <= FLAG_RESET;
         s_q.active <= ACTIVE_RESET;
         s_q.vector <= VECTOR_BASE;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   // Zero-wait slave; read data was prepared in setup
   assign pready = 1'b1;
   assign prdata = s_q.rdata;
   assign pslverr = s_q.slverr;
   assign irq_call = s_q.call;
   assign irq_vector = s_q.vector;
   assign irq_source = s_q.call_src;
   assign irq_level = s_q.call_level;
endmodule

// ==== fvirq_top_properties.sv ====
`timescale 1ns/1ps
module fvirq_top_properties
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // APB
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Flags and CPU sequencer
   input wire logic [fvirq_pkg::NUM_FLAG-1:0] flag_set,
   input wire logic [2:0] ext_edge_mode,
   input wire logic cpu_call_slot,
   input wire logic cpu_reti,
   input wire logic irq_call,
   input wire logic [15:0] irq_vector,
   input wire logic [4:0] irq_source,
   input wire logic [1:0] irq_level
);
   import fvirq_pkg::*;
   // ------------------------------------------------------------
   // Helper state
   // ------------------------------------------------------------
   // Only a call with no return since the last one is known to sit above a live level
   typedef struct packed {logic fresh; logic [1:0] lvl;} fvirq_chk_type;
   fvirq_chk_type chk_q;
   fvirq_chk_type chk_d;
   wire unmapped = (paddr[1:0] != 2'b00) || (paddr > 8'h1c);
   always_comb
   begin
      chk_d = chk_q;
      if (irq_call)
         chk_d = '{fresh: 1'b1, lvl: irq_level};
      else if (cpu_reti)
         chk_d.fresh = 1'b0;
   end
   always_ff @(posedge clk)
      chk_q <= reset ? '0 : chk_d;
   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_call_pulse: assert property (irq_call |=> !irq_call)
      else $error("call pulse longer than one cycle");
   chk_vector_map: assert property (irq_call |-> irq_vector == 16'h0003 + {8'h00, irq_source, 3'b000})
      else $error("vector does not match source");
   chk_no_reserved: assert property (irq_call |-> irq_source <= 5'd18 && !(irq_source inside {13, 15, 17}))
      else $error("call for a reserved source");
   chk_call_slot: assert property (irq_call |-> $past(cpu_call_slot) && !$past(cpu_reti))
      else $error("call without slot or during return");
   chk_vector_hold: assert property (!irq_call && !$past(reset) |-> $stable({irq_vector, irq_source, irq_level}))
      else $error("call outputs moved without a call");
   chk_apb_ready: assert property (psel && penable |-> pready)
      else $error("access phase without ready");
   chk_slverr_map: assert property (psel && penable |-> pslverr == unmapped)
      else $error("error response does not match address map");
   chk_unmapped_zero: assert property (psel && penable && !pwrite && unmapped |-> prdata == 32'h0)
      else $error("unmapped read returned data");
   chk_reset_quiet: assert property ($fell(reset) |-> !irq_call [*3])
      else $error("call too soon after reset");
   chk_no_preempt: assert property (irq_call && chk_q.fresh |-> irq_level > chk_q.lvl)
      else $error("nested call not of higher level");
   cover property (irq_call && irq_level == 2'b11);
   cover property (psel && penable && pslverr);
   cover property (cpu_reti ##[1:20] irq_call);
endmodule
bind fvirq_top fvirq_top_properties u_props (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .flag_set(flag_set), .ext_edge_mode(ext_edge_mode), .cpu_call_slot(cpu_call_slot), .cpu_reti(cpu_reti),
   .irq_call(irq_call), .irq_vector(irq_vector), .irq_source(irq_source), .irq_level(irq_level));

// ==== fvirq_cpu_model.sv ====
`timescale 1ns/1ps
module fvirq_cpu_model
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Bench control
   input wire logic slow,
   input wire logic ret_req,
   // Sequencer side
   output logic cpu_call_slot,
   output logic cpu_reti
);
   logic [1:0] phase_q;
   always_ff @(posedge clk)
   begin
      phase_q <= reset ? 2'b00 : phase_q + 2'b01;
      cpu_reti <= !reset && ret_req;
   end
   // Slow mode ends an instruction only every fourth cycle, so calls must wait for it
   assign cpu_call_slot = !reset && (!slow || phase_q == 2'b11);
endmodule

// ==== fvirq_top_tb.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) check_val(64'(got), 64'(exp))
module fvirq_top_tb;
   import fvirq_pkg::*;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, slow, ret_req, err;
   logic cpu_call_slot, cpu_reti, irq_call;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NUM_FLAG-1:0] flag_set;
   logic [2:0] ext_edge_mode;
   logic [15:0] irq_vector;
   logic [4:0] irq_source;
   logic [1:0] irq_level;
   int bad_count, samples_checked, cycles;
   fvirq_top uut (.clk(clk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .flag_set(flag_set),
      .ext_edge_mode(ext_edge_mode), .cpu_call_slot(cpu_call_slot), .cpu_reti(cpu_reti), .irq_call(irq_call),
      .irq_vector(irq_vector), .irq_source(irq_source), .irq_level(irq_level));
   fvirq_cpu_model model (.clk(clk), .reset(reset), .slow(slow), .ret_req(ret_req),
      .cpu_call_slot(cpu_call_slot), .cpu_reti(cpu_reti));
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Wide enough to carry the error response next to a full data word
   task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("comparisons=%0d mismatches=%0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // Hang guard, well above the thousand or so cycles the run needs
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      {psel, penable, paddr, pwrite, pwdata} <= {1'b1, 1'b0, a, w, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      // Only the hang guard ends a wait for the answer
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic ret();
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask
   task automatic ret_clear();
      apb(OFS_FLAGS_LO, 1'b1, 32'h0);
      apb(OFS_FLAGS_HI, 1'b1, 32'h0);
      ret();
   endtask
   task automatic raise(input int f, input bit hw);
      if (!hw)
         apb(f < 32 ? OFS_FLAGS_LO : OFS_FLAGS_HI, 1'b1, 32'h1 << (f % 32));
      else
      begin
         @(posedge clk);
         flag_set[f] <= 1'b1;
         @(posedge clk);
         flag_set <= '0;
      end
   endtask
   task automatic no_call(input int m);
      repeat (m)
      begin
         @(negedge clk);
         `CHK(irq_call, 0);
      end
   endtask
   // A pulsed flag calls in the third cycle after the pulse when the slot is open
   task automatic expect_call(input int src, input logic [1:0] lvl, input bit lat);
      int n;
      for (n = 1; n <= 40; n++)
      begin
         @(negedge clk);
         if (irq_call === 1'b1)
            break;
      end
      `CHK(irq_call, 1);
      if (lat)
         `CHK(n, 3);
      `CHK(irq_source, src);
      `CHK(irq_vector, 3 + 8 * src);
      `CHK(irq_level, lvl);
   endtask
   function automatic int src_of(input int f);
      int lim[16] = '{1, 2, 3, 4, 6, 9, 10, 11, 14, 23, 31, 32, 33, 35, 38, 41};
      int num[16] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 14, 16, 18};
      src_of = 10;
      for (int i = 15; i >= 0; i--)
         if (f < lim[i])
            src_of = num[i];
   endfunction
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic test_regs();
      `CHK(irq_vector, 16'h0003);
      for (int a = 0; a <= 'h1c; a += 4)
      begin
         apb(8'(a), 1'b0, 32'h0);
         `CHK({err, rd}, 0);
      end
      apb(8'h20, 1'b0, 32'h0);
      `CHK({err, rd}, 33'h1_0000_0000);
      for (int a = 0; a <= 8; a += 4)
      begin
         apb(8'(a), 1'b1, 32'hffff_ffff);
         apb(8'(a), 1'b0, 32'h0);
         `CHK(rd, a == 0 ? 32'h8005_5fff : 32'h0005_5fff);
         apb(8'(a), 1'b1, 32'h0);
      end
   endtask
   task automatic test_gate();
      apb(OFS_ENABLE, 1'b1, 32'h0000_0002);
      raise(1, 1'b1);
      no_call(10);
      apb(OFS_ENABLE, 1'b1, 32'h8000_0000);
      no_call(10);
      apb(OFS_ENABLE, 1'b1, 32'h8000_0002);
      expect_call(1, 2'b00, 1'b0);
      ret_clear();
   endtask
   task automatic test_flags();
      apb(OFS_ENABLE, 1'b1, 32'h8007_ffff);
      for (int f = 0; f < 41; f++)
      begin
         raise(f, f % 2 == 0);
         expect_call(src_of(f), 2'b00, f % 2 == 0);
         apb(f < 32 ? OFS_FLAGS_LO : OFS_FLAGS_HI, 1'b0, 32'h0);
         `CHK(rd, f inside {0, 1, 3, 9} ? 32'h0 : 32'h1 << (f % 32));
         ret_clear();
      end
      apb(OFS_CONFIG, 1'b1, 32'h1);
      raise(41, 1'b1);
      expect_call(10, 2'b00, 1'b1);
      ret_clear();
      apb(OFS_CONFIG, 1'b1, 32'h0);
      raise(41, 1'b1);
      no_call(8);
      ret_clear();
   endtask
   task automatic test_priority();
      apb(OFS_ENABLE, 1'b1, 32'h0007_ffff);
      apb(OFS_PRIO_HIGH, 1'b1, 32'h0004_0210);
      apb(OFS_PRIO_LOW, 1'b1, 32'h0004_0001);
      apb(OFS_FLAGS_HI, 1'b1, 32'h40);
      apb(OFS_FLAGS_LO, 1'b1, 32'h4011);
      apb(OFS_ENABLE, 1'b1, 32'h8007_ffff);
      expect_call(18, 2'b11, 1'b0);
      no_call(8);
      apb(OFS_FLAGS_HI, 1'b1, 32'h0);
      ret();
      expect_call(4, 2'b10, 1'b0);
      apb(OFS_FLAGS_LO, 1'b1, 32'h4001);
      ret();
      expect_call(9, 2'b10, 1'b0);
      apb(OFS_FLAGS_LO, 1'b1, 32'h1);
      ret();
      expect_call(0, 2'b01, 1'b0);
      apb(OFS_FLAGS_HI, 1'b1, 32'h40);
      expect_call(18, 2'b11, 1'b0);
      apb(OFS_STATUS, 1'b0, 32'h0);
      `CHK(rd, 32'h0000_0074);
      apb(OFS_PENDING, 1'b0, 32'h0);
      `CHK(rd, 32'h0004_0000);
      ret_clear();
      ret();
      apb(OFS_PRIO_HIGH, 1'b1, 32'h0);
      apb(OFS_PRIO_LOW, 1'b1, 32'h0);
   endtask
   task automatic test_slow();
      slow <= 1'b1;
      raise(3, 1'b1);
      expect_call(3, 2'b00, 1'b0);
      ret_clear();
      slow <= 1'b0;
   endtask
   initial
   begin
      {reset, psel, penable, pwrite, paddr, pwdata, flag_set} = {4'b1000, 8'h00, 32'h0, 42'h0};
      {ext_edge_mode, slow, ret_req} = {3'b101, 2'b00};
      {bad_count, samples_checked, cycles} = {32'd0, 32'd0, 32'd0};
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      test_regs();
      test_gate();
      test_flags();
      test_priority();
      test_slow();
      finish_test();
   end
endmodule
